// >>> src/acf_defs.svh
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH

// ==========================================================
// register byte offsets
`define ACF_ADDR_CFG        8'h00
`define ACF_ADDR_CTRL       8'h04
`define ACF_ADDR_STAT       8'h08
`define ACF_ADDR_RESULT     8'h0c
`define ACF_ADDR_ROUTE      8'h10

// ==========================================================
// configuration, control and status register fields
`define ACF_CFG_W           14
`define ACF_CFG_RST         14'h3fff
`define ACF_INCFG_HI        12
`define ACF_INCFG_LO        10
`define ACF_CHAN_HI         9
`define ACF_CHAN_LO         7
`define ACF_BW_BIT          6
`define ACF_CTRL_SEQ_BIT    0
`define ACF_STAT_BUSY_BIT   0
`define ACF_STAT_VALID_BIT  1

// ==========================================================
// input configuration codes
`define ACF_INCFG_SINGLE    3'b111
`define ACF_INCFG_COM_BIP   3'b010
`define ACF_INCFG_COM_UNI   3'b110
`define ACF_INCFG_PAIR_BIP  2'b00
`define ACF_INCFG_PAIR_UNI  2'b10

// ==========================================================
// output code limits
`define ACF_UNI_MAX         16'hffff
`define ACF_UNI_MIN         16'h0000
`define ACF_BIP_MAX         16'h7fff
`define ACF_BIP_MIN         16'h8000
`define ACF_UNI_TOP         18'sh0ffff
`define ACF_BIP_TOP         18'sh07fff
`define ACF_BIP_BOT         -18'sh08000

// ==========================================================
// conversion timing on the internal conversion clock
`define ACF_CONV_DIV_LAST   2'd3
`define ACF_CONV_STEP_LAST  4'd15
`define ACF_CONV_CYC_LAST   7'd63

`endif

// >>> src/acf_pkg.sv
package acf_pkg;

   typedef enum logic [1:0] {ACF_NEG_GND, ACF_NEG_COM, ACF_NEG_PAIR} acf_neg_t;

   typedef enum logic {ACF_ACQ, ACF_CONV} acf_state_t;

   typedef struct packed {
      logic [2:0] pos;
      acf_neg_t   neg;
      logic [2:0] neg_ch;
      logic       bipolar;
   } acf_route_t;

endpackage

// >>> src/acf_fmt_if.sv
`timescale 1ns/100ps
interface acf_fmt_if;
   logic               load;
   logic signed [17:0] diff;
   logic               bipolar;
   logic [15:0]        code;
   logic               done;

   modport fmt (input load, input diff, input bipolar, output code, output done);
   modport ctl (output load, output diff, output bipolar, input code, input done);
endinterface

// >>> src/acf_code_format.sv
`timescale 1ns/100ps
`include "acf_defs.svh"
module acf_code_format
(
   input  logic           clk_sys_i,
   input  logic           rst_i,
   acf_fmt_if.fmt         f
);

   logic [15:0] code_q;
   logic        done_q;

   // ==========================================================
   // saturate and encode
   function automatic logic [15:0] sat_code(input logic signed [17:0] d, input logic bip);
      logic [15:0] c;
      c = d[15:0];
      if (bip)
      begin
         if (d > `ACF_BIP_TOP)
            c = `ACF_BIP_MAX;
         else if (d < `ACF_BIP_BOT)
            c = `ACF_BIP_MIN;
      end
      else
      begin
         if (d > `ACF_UNI_TOP)
            c = `ACF_UNI_MAX;
         else if (d < 18'sd0)
            c = `ACF_UNI_MIN;
      end
      return c;
   endfunction

   // in range the low 16 bits already are straight binary or twos complement
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         code_q <= 16'h0000;
      else if (f.load)
         code_q <= sat_code(f.diff, f.bipolar);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         done_q <= 1'b0;
      else
         done_q <= f.load;
   end

   assign f.code = code_q;
   assign f.done = done_q;

   // ==========================================================
   // checks
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_uni_over_sat: assert property (f.load && !f.bipolar && f.diff > 18'sh0ffff |=> f.code == 16'hffff)
      else $error("unipolar overrange not saturated");
   a_bip_over_sat: assert property (f.load && f.bipolar && f.diff > 18'sh07fff |=> f.code == 16'h7fff)
      else $error("bipolar overrange not saturated");
   a_under_sat: assert property (f.load && (f.bipolar ? f.diff < -18'sh08000 : f.diff < 18'sd0)
                                 |=> f.code == ($past(f.bipolar) ? 16'h8000 : 16'h0000))
      else $error("underrange not saturated");
   a_mid_codes: assert property (f.load && f.diff == (f.bipolar ? 18'sd1 : 18'sd32769) |=> f.code == ($past(f.bipolar) ? 16'h0001 : 16'h8001) ##0 f.done)
      else $error("midscale plus one code wrong");
   a_straight_code: assert property (f.load && !f.bipolar && f.diff >= 0 && f.diff <= 18'sh0ffff |=> f.code == $past(f.diff[15:0]))
      else $error("straight binary code wrong");
   a_twos_code: assert property (f.load && f.bipolar && f.diff >= -18'sh08000 && f.diff <= 18'sh07fff |=> f.code == $past(f.diff[15:0]))
      else $error("twos complement code wrong");

endmodule

// >>> src/acf_input_config.sv
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "acf_defs.svh"
// Functional notes
// - unipolar input configurations give straight binary results
// - bipolar input configurations give twos complement results
// - overrange saturates at 0xffff unipolar or 0x7fff bipolar
// - underrange saturates at 0x0000 unipolar or 0x8000 bipolar
// - midscale gives 0x8000 or 0x0000; one step above adds one
// - bandwidth bit selects full or quarter bandwidth input filter
// - input code 111: every input single-ended against ground, unipolar
// - input code 010: input against common at half reference, bipolar
// - input code 110: input against common as ground sense, unipolar
// - input codes 00x: pairs, negative member at half reference, bipolar
// - input codes 10x: pairs, negative member is ground sense, unipolar
// - paired: even channel value puts positive on even input, odd on odd
// - paired: channel 101 pairs inputs four and five, five positive
// - sequencer in paired modes always uses even inputs as positive
// - convert input rise ends acquisition, conversion runs on internal clock
module acf_input_config
(
   input  logic               clk_sys_i,
   input  logic               rst_i,
   input  logic               hsel_i,
   input  logic [31:0]        haddr_i,
   input  logic [1:0]         htrans_i,
   input  logic               hwrite_i,
   input  logic [2:0]         hsize_i,
   input  logic [31:0]        hwdata_i,
   input  logic               hready_i,
   output logic               hreadyout_o,
   output logic               hresp_o,
   output logic [31:0]        hrdata_o,
   input  logic               convert_start_i,
   input  logic signed [17:0] sample_diff_i,
   output logic [2:0]         positive_input_o,
   output acf_pkg::acf_neg_t  negative_kind_o,
   output logic [2:0]         negative_input_o,
   output logic               bipolar_o,
   output logic               filter_bandwidth_o,
   output logic               busy_o,
   output logic [15:0]        result_o,
   output logic               result_valid_o
);
   import acf_pkg::*;

   acf_fmt_if  fmt_if ();

   logic                 ap_valid_q;
   logic                 ap_write_q;
   logic [7:0]           ap_addr_q;
   logic                 rd_done_q;
   logic [31:0]          hrdata_q;
   logic                 take;
   logic                 wr_en;
   logic                 rd_en;
   logic                 cfg_wr;
   logic [`ACF_CFG_W-1:0] cfg_q;
   logic                 seq_en_q;
   logic                 valid_q;
   logic                 cnv_meta_q;
   logic                 cnv_sync_q;
   logic                 cnv_prev_q;
   logic                 cnv_rise;
   acf_state_t           state_q;
   logic [1:0]           div_q;
   logic [3:0]           step_q;
   logic                 conv_tick;
   logic                 conv_end;
   logic [6:0]           cyc_q;
   logic [2:0]           seq_idx_q;
   logic [2:0]           seq_last;
   logic                 paired;
   acf_route_t           route_q;
   logic signed [17:0]   samp_q;
   logic                 load_q;
   logic [2:0]           incfg;
   logic [2:0]           chan;

   // ==========================================================
   // configuration decode
   assign incfg  = cfg_q[`ACF_INCFG_HI:`ACF_INCFG_LO];
   assign chan   = cfg_q[`ACF_CHAN_HI:`ACF_CHAN_LO];
   assign paired = (incfg[2:1] == `ACF_INCFG_PAIR_BIP) || (incfg[2:1] == `ACF_INCFG_PAIR_UNI);

   function automatic acf_route_t decode(input logic [2:0] ic, input logic [2:0] ch,
                                         input logic seq, input logic [2:0] idx);
      acf_route_t r;
      r.pos     = seq ? idx : ch;
      r.neg     = ACF_NEG_GND;
      r.neg_ch  = 3'h0;
      r.bipolar = 1'b0;
      if (ic == `ACF_INCFG_COM_BIP)
      begin
         r.neg     = ACF_NEG_COM;
         r.bipolar = 1'b1;
      end
      else if (ic == `ACF_INCFG_COM_UNI)
         r.neg = ACF_NEG_COM;
      else if (ic[2:1] == `ACF_INCFG_PAIR_BIP || ic[2:1] == `ACF_INCFG_PAIR_UNI)
      begin
         r.neg     = ACF_NEG_PAIR;
         r.bipolar = (ic[2:1] == `ACF_INCFG_PAIR_BIP);
         r.pos     = seq ? {idx[1:0], 1'b0} : ch;
         r.neg_ch  = r.pos ^ 3'h1;
      end
      // 111 and the unused 011 both fall to single-ended against ground
      return r;
   endfunction

   // ==========================================================
   // bus slave
   assign take   = hsel_i && hready_i && htrans_i[1];
   assign wr_en  = ap_valid_q && ap_write_q;
   assign rd_en  = ap_valid_q && !ap_write_q && !rd_done_q;
   assign cfg_wr = wr_en && (ap_addr_q == `ACF_ADDR_CFG);

   // one wait state on reads so a read right after a write sees the new value
   assign hreadyout_o = !rd_en;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q  <= 8'h00;
      end
      else if (hready_i)
      begin
         ap_valid_q <= take;
         if (take)
         begin
            ap_write_q <= hwrite_i;
            ap_addr_q  <= {haddr_i[7:2], 2'b00};
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         rd_done_q <= 1'b0;
      else if (hready_i)
         rd_done_q <= 1'b0;
      else if (rd_en)
         rd_done_q <= 1'b1;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         hrdata_q <= 32'h0000_0000;
      else if (rd_en)
      begin
         unique case (ap_addr_q)
            `ACF_ADDR_CFG:    hrdata_q <= {18'h00000, cfg_q};
            `ACF_ADDR_CTRL:   hrdata_q <= {31'h0000_0000, seq_en_q};
            `ACF_ADDR_STAT:   hrdata_q <= {30'h0000_0000, valid_q, busy_o};
            `ACF_ADDR_RESULT: hrdata_q <= {16'h0000, fmt_if.code};
            `ACF_ADDR_ROUTE:  hrdata_q <= {22'h00_0000, route_q.bipolar, route_q.neg_ch,
                                           route_q.neg, 1'b0, route_q.pos};
            default:          hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // configuration word changes only here
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         cfg_q <= `ACF_CFG_RST;
      else if (cfg_wr)
         cfg_q <= hwdata_i[`ACF_CFG_W-1:0];
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         seq_en_q <= 1'b0;
      else if (wr_en && ap_addr_q == `ACF_ADDR_CTRL)
         seq_en_q <= hwdata_i[`ACF_CTRL_SEQ_BIT];
   end

   // new result sets, result read clears; set wins
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         valid_q <= 1'b0;
      else if (fmt_if.done)
         valid_q <= 1'b1;
      else if (rd_en && ap_addr_q == `ACF_ADDR_RESULT)
         valid_q <= 1'b0;
   end

   // ==========================================================
   // convert input: pin, so two flops before any use
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnv_meta_q <= 1'b0;
         cnv_sync_q <= 1'b0;
         cnv_prev_q <= 1'b0;
      end
      else
      begin
         cnv_meta_q <= convert_start_i;
         cnv_sync_q <= cnv_meta_q;
         cnv_prev_q <= cnv_sync_q;
      end
   end

   assign cnv_rise = cnv_sync_q && !cnv_prev_q;

   // ==========================================================
   // conversion sequence on the internal conversion clock enable
   assign conv_tick = (state_q == ACF_CONV) && (div_q == `ACF_CONV_DIV_LAST);
   assign conv_end  = conv_tick && (step_q == `ACF_CONV_STEP_LAST);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         state_q <= ACF_ACQ;
      else
      begin
         unique case (state_q)
            ACF_ACQ:  if (cnv_rise) state_q <= ACF_CONV;
            ACF_CONV: if (conv_end) state_q <= ACF_ACQ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || state_q == ACF_ACQ)
      begin
         div_q  <= 2'd0;
         step_q <= 4'd0;
         cyc_q  <= 7'd0;
      end
      else
      begin
         div_q <= div_q + 2'd1;
         cyc_q <= cyc_q + 7'd1;
         if (conv_tick)
            step_q <= step_q + 4'd1;
      end
   end

   // sample is taken when acquisition ends; a rise while converting is ignored
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         samp_q <= 18'sd0;
      else if (state_q == ACF_ACQ && cnv_rise)
         samp_q <= sample_diff_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         load_q <= 1'b0;
      else
         load_q <= conv_end;
   end

   // ==========================================================
   // sequencer
   assign seq_last = paired ? {1'b0, chan[2:1]} : chan;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !seq_en_q)
         seq_idx_q <= 3'd0;
      else if (conv_end)
         seq_idx_q <= (seq_idx_q >= seq_last) ? 3'd0 : seq_idx_q + 3'd1;
   end

   // routing follows the settings while acquiring and is frozen while converting
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         route_q <= decode(3'(`ACF_CFG_RST >> `ACF_INCFG_LO), 3'h7, 1'b0, 3'h0);
      else if (state_q == ACF_ACQ)
         route_q <= decode(incfg, chan, seq_en_q, seq_idx_q);
   end

   // ==========================================================
   // code formatting
   assign fmt_if.load    = load_q;
   assign fmt_if.diff    = samp_q;
   assign fmt_if.bipolar = route_q.bipolar;

   acf_code_format u_format
   (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .f         (fmt_if.fmt)
   );

   assign positive_input_o   = route_q.pos;
   assign negative_kind_o    = route_q.neg;
   assign negative_input_o   = route_q.neg_ch;
   assign bipolar_o          = route_q.bipolar;
   assign filter_bandwidth_o = cfg_q[`ACF_BW_BIT];
   assign busy_o             = (state_q == ACF_CONV) || load_q;
   assign result_o           = fmt_if.code;
   assign result_valid_o     = valid_q;

   // ==========================================================
   // checks
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_conv_start: assert property (state_q == ACF_ACQ && cnv_rise |=> busy_o && samp_q == $past(sample_diff_i))
      else $error("conversion did not start on convert rise");
   a_conv_length: assert property (load_q |-> $past(cyc_q) == `ACF_CONV_CYC_LAST)
      else $error("conversion length wrong");
   a_route_frozen: assert property (state_q == ACF_CONV && $past(state_q) == ACF_CONV |-> $stable(route_q))
      else $error("routing changed during conversion");
   a_cfg_hold: assert property (!cfg_wr |=> $stable(cfg_q))
      else $error("configuration changed without a write");
   a_single_gnd: assert property (state_q == ACF_ACQ && incfg == 3'b111 && !seq_en_q |=> route_q.neg == ACF_NEG_GND && !bipolar_o && positive_input_o == $past(chan))
      else $error("single-ended routing wrong");
   a_com_modes: assert property (state_q == ACF_ACQ && incfg[1:0] == 2'b10 |=> route_q.neg == ACF_NEG_COM && bipolar_o == !$past(incfg[2]))
      else $error("common input routing wrong");
   a_pair_modes: assert property (state_q == ACF_ACQ && paired |=> route_q.neg == ACF_NEG_PAIR && bipolar_o == !$past(incfg[2]) && negative_input_o == (positive_input_o ^ 3'h1))
      else $error("paired routing wrong");
   a_pair_select: assert property (state_q == ACF_ACQ && paired && !seq_en_q && chan == 3'b101 |=> positive_input_o == 3'd5 && negative_input_o == 3'd4)
      else $error("pair selection wrong");
   a_seq_even: assert property (state_q == ACF_ACQ && paired && seq_en_q |=> !positive_input_o[0])
      else $error("sequencer used odd positive input");
   a_bw_select: assert property (cfg_wr |=> filter_bandwidth_o == $past(hwdata_i[6]))
      else $error("filter bandwidth not taken from word");

endmodule

// >>> tb/acf_host_model.sv
`timescale 1ns/100ps
`include "acf_defs.svh"
// =====
// host: bus master and sample source
module acf_host_model
(
   input  logic               clk_sys_i,
   input  logic               hready_i,
   input  logic [31:0]        hrdata_i,
   input  logic               busy_i,
   output logic               hsel_o,
   output logic [31:0]        haddr_o,
   output logic [1:0]         htrans_o,
   output logic               hwrite_o,
   output logic [2:0]         hsize_o,
   output logic [31:0]        hwdata_o,
   output logic               convert_start_o,
   output logic signed [17:0] sample_diff_o,
   output logic               timeout_o
);
   initial
   begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'b00;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0;
      convert_start_o = 1'b0;
      sample_diff_o = 18'sh0;
      timeout_o = 1'b0;
   end

   // =====
   // waits: levels settle mid-cycle, so sample there
   task automatic wait_pin(input logic bus, input logic want, input int lim, output logic [31:0] q, inout int n);
      logic r;
      r = ~want;
      while (r !== want && lim > 0)
      begin
         @(negedge clk_sys_i);
         r = bus ? hready_i : busy_i;
         q = hrdata_i;
         @(posedge clk_sys_i);
         lim--;
         n++;
      end
      if (r !== want)
         timeout_o = 1'b1;
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys_i);
      hsel_o <= 1'b1;
      haddr_o <= a;
      htrans_o <= 2'b10;
      hwrite_o <= wr;
      wait_pin(1'b1, 1'b1, 40, q, n);
      htrans_o <= 2'b00;
      hwdata_o <= d;
      wait_pin(1'b1, 1'b1, 40, q, n);
      hsel_o <= 1'b0;
      hwdata_o <= ~d;
   endtask

   // only 14 bits make the configuration word
   task automatic cfg_write(input logic [13:0] w);
      logic [31:0] q;
      xfer(1'b1, {24'h0, `ACF_ADDR_CFG}, {18'h0, w}, q);
   endtask

   // quarter bandwidth needs a longer acquisition
   task automatic convert(input logic signed [17:0] d, input logic quarter, output int n);
      logic [31:0] q;
      repeat (quarter ? 200 : 3) @(posedge clk_sys_i);
      sample_diff_o <= d;
      convert_start_o <= 1'b1;
      n = 0;
      wait_pin(1'b0, 1'b1, 20, q, n);
      sample_diff_o <= ~d;
      wait_pin(1'b0, 1'b0, 100, q, n);
      convert_start_o <= 1'b0;
   endtask
endmodule

// >>> tb/acf_input_config_tb_top.sv
`timescale 1ns/100ps
`include "acf_defs.svh"
module acf_input_config_tb_top;
   import acf_pkg::*;
   // =====
   // nets
   logic               clk_sys_i, rst_i, hsel, hwrite, hready, hresp, cst;
   logic               bipolar, bw, busy, valid, host_to;
   logic [1:0]         htrans;
   logic [2:0]         hsize, pos, neg_in;
   logic [31:0]        haddr, hwdata, hrdata, q, w;
   logic [15:0]        result;
   logic signed [17:0] diff;
   acf_neg_t           kind;
   acf_route_t         r;
   int                 fails, compares, seed, n, d;
   int                 uni_d [8] = '{65536, 70000, -1, -9000, 32768, 32769, 65535, 0};
   int                 bip_d [8] = '{32768, -32769, 0, 1, -1, 32767, -32768, 40000};
   localparam logic [31:0] CFG = {24'h0, `ACF_ADDR_CFG};

   acf_input_config DUT
   (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
      .convert_start_i(cst), .sample_diff_i(diff), .positive_input_o(pos),
      .negative_kind_o(kind), .negative_input_o(neg_in), .bipolar_o(bipolar),
      .filter_bandwidth_o(bw), .busy_o(busy), .result_o(result), .result_valid_o(valid)
   );

   acf_host_model host
   (
      .clk_sys_i(clk_sys_i), .hready_i(hready), .hrdata_i(hrdata), .busy_i(busy),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hsize_o(hsize), .hwdata_o(hwdata), .convert_start_o(cst),
      .sample_diff_o(diff), .timeout_o(host_to)
   );

   always #12.5 clk_sys_i = ~clk_sys_i;

   // =====
   // checking and verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge host_to)
   begin
      fails++;
      $display("mismatch at %0t: wait ran out", $time);
      summarize();
   end

   function automatic logic [15:0] exp_code(input logic b, input int d);
      if (b)
         return d > 32767 ? 16'h7fff : (d < -32768 ? 16'h8000 : d[15:0]);
      return d > 65535 ? 16'hffff : (d < 0 ? 16'h0000 : d[15:0]);
   endfunction

   function automatic acf_route_t exp_route(input logic [2:0] ic, input logic [2:0] ch);
      acf_route_t e;
      e.pos = ch;
      e.neg = ic[1] ? (ic[0] ? ACF_NEG_GND : ACF_NEG_COM) : ACF_NEG_PAIR;
      e.neg_ch = ic[1] ? 3'h0 : ch ^ 3'h1;
      e.bipolar = ic == 3'b010 || ic[2:1] == 2'b00;
      return e;
   endfunction

   task automatic conv_check(input logic b, input int d);
      logic [15:0] e;
      e = exp_code(b, d);
      host.convert(18'(d), b, n);
      // valid flag is launched by the edge the host returns on
      @(negedge clk_sys_i);
      check({16'h0, result}, {16'h0, e});
      check({31'h0, valid}, 32'h1);
      check({31'h0, n >= 66 && n <= 72}, 32'h1);
      host.xfer(1'b0, {24'h0, `ACF_ADDR_RESULT}, 32'h0, q);
      check(q, {16'h0, e});
      host.xfer(1'b0, {24'h0, `ACF_ADDR_STAT}, 32'h0, q);
      check(q, 32'h0);
   endtask

   // =====
   // scenarios
   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      fails++;
      $display("mismatch at %0t: run too long", $time);
      summarize();
   end

   initial
   begin
      clk_sys_i = 1'b0;
      seed = 56745;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(negedge clk_sys_i);
      check({31'h0, bw}, 32'h1);
      check({31'h0, hresp}, 32'h0);
      host.xfer(1'b1, 32'h14, 32'hffffffff, q);
      host.xfer(1'b0, 32'h14, 32'h0, q);
      check(q, 32'h0);
      host.xfer(1'b0, CFG, 32'h0, q);
      check(q, {18'h0, `ACF_CFG_RST});
      // every input code, random and odd channels
      for (int i = 0; i < 16; i++)
      begin
         w = $random(seed);
         w[31:14] = 18'h0;
         w[12:10] = i[3:1];
         if (i[0])
            w[9:7] = 3'b101;
         r = exp_route(w[12:10], w[9:7]);
         host.cfg_write(w[13:0]);
         repeat (2) @(negedge clk_sys_i);
         check({29'h0, pos}, {29'h0, r.pos});
         check({30'h0, kind}, {30'h0, r.neg});
         check({29'h0, neg_in}, {29'h0, r.neg_ch});
         check({31'h0, bipolar}, {31'h0, r.bipolar});
         check({31'h0, bw}, {31'h0, w[6]});
         host.xfer(1'b0, {24'h0, `ACF_ADDR_ROUTE}, 32'h0, q);
         check(q, {22'h0, r.bipolar, r.neg_ch, r.neg, 1'b0, r.pos});
         host.xfer(1'b0, CFG, 32'h0, q);
         check(q, w);
      end
      // corner codes, then random ones
      for (int b = 0; b < 2; b++)
      begin
         host.cfg_write({1'b0, b[0] ? 3'b010 : 3'b111, 3'h0, ~b[0], 6'h0});
         for (int k = 0; k < 12; k++)
         begin
            d = k < 8 ? (b[0] ? bip_d[k] : uni_d[k]) : $random(seed) % 90000;
            conv_check(b[0], d);
         end
      end
      // routing must hold while converting
      host.cfg_write({1'b0, 3'b111, 3'h2, 1'b1, 6'h0});
      fork
         host.convert(18'sh00064, 1'b0, n);
         begin
            for (int k = 0; k < 20 && busy !== 1'b1; k++)
               @(negedge clk_sys_i);
            check({31'h0, busy}, 32'h1);
            host.cfg_write({1'b0, 3'b111, 3'h6, 1'b1, 6'h0});
            @(negedge clk_sys_i);
            check({29'h0, pos}, 32'h2);
         end
      join
      repeat (2) @(negedge clk_sys_i);
      check({29'h0, pos}, 32'h6);
      // sequencer with odd pair option still scans even inputs
      host.cfg_write({1'b0, 3'b000, 3'b101, 1'b1, 6'h0});
      host.xfer(1'b1, {24'h0, `ACF_ADDR_CTRL}, 32'h1, q);
      for (int k = 0; k < 4; k++)
      begin
         repeat (2) @(negedge clk_sys_i);
         check({29'h0, pos}, 32'((k % 3) * 2));
         host.convert(18'sh00005, 1'b0, n);
      end
      host.xfer(1'b1, {24'h0, `ACF_ADDR_CTRL}, 32'h0, q);
      summarize();
   end
endmodule
